// ---- pvic_pkg.sv ----
// Package for the prioritized vector interrupt arbiter: register offsets,
// field positions, reset values and the bus request carrier.
// Assumes a 16-bit peripheral register bus with word offsets.
package pvic_pkg;

	localparam int NUM_SRC    = 86;
	localparam int SRC_W      = 7;
	localparam int LVL_W      = 2;
	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 6;
	localparam int VBA_W      = 13;
	localparam int FAH_W      = 5;
	localparam int VADDR_W    = 21;
	localparam int PRIO_WORDS = 11;
	localparam int PEND_WORDS = 6;
	localparam int FLD_PER_WD = 8;

	// Register offsets, one 16-bit word each.
	localparam logic [ADDR_W-1:0] OFS_PRIO_FIRST = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_PRIO_LAST  = 6'h09;
	localparam logic [ADDR_W-1:0] OFS_VBA        = 6'h0A;
	localparam logic [ADDR_W-1:0] OFS_FM0        = 6'h0B;
	localparam logic [ADDR_W-1:0] OFS_FAL0       = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_FAH0       = 6'h0D;
	localparam logic [ADDR_W-1:0] OFS_FM1        = 6'h0E;
	localparam logic [ADDR_W-1:0] OFS_FAL1       = 6'h0F;
	localparam logic [ADDR_W-1:0] OFS_FAH1       = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_PEND_FIRST = 6'h11;
	localparam logic [ADDR_W-1:0] OFS_PEND_LAST  = 6'h16;
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 6'h1D;
	localparam logic [ADDR_W-1:0] OFS_PRIO10     = 6'h1F;
	localparam logic [3:0]        PRIO10_IDX     = 4'hA;

	// Control register fields.
	localparam int CTRL_EDGE_A = 0;
	localparam int CTRL_EDGE_B = 1;
	localparam int CTRL_LVL_LO = 2;
	localparam int CTRL_WAKE   = 4;

	// Reset values.
	localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
	localparam logic [1:0]        RST_EDGE = 2'h0;

	// Source assignments for fixed and clockless sources.
	localparam int                NUM_FIXED    = 2;
	localparam logic [LVL_W-1:0]  FIXED_LVL    = 2'h3;
	localparam logic [LVL_W-1:0]  FAST_LVL     = 2'h2;
	localparam int                PIN_A_SRC    = 2;
	localparam int                PIN_B_SRC    = 3;
	localparam int                CAN_WAKE_SRC = 4;

	// One register bus request, valid for one cycle.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pvic_bus_req_t;

endpackage : pvic_pkg

// ---- pvic_prio_mem.sv ----
// Storage for the priority level words; every field is visible at once.
// Assumes writes come from the arbiter's register decode, one word a cycle.
`timescale 1ns/1ps
module pvic_prio_mem (
	input  wire logic                                          ref_clk_i,
	input  wire logic                                          rst_i,
	input  wire logic                                          wr_en_i,
	input  wire logic [3:0]                                    wr_idx_i,
	input  wire logic [pvic_pkg::DATA_W-1:0]                   wr_data_i,
	output logic [pvic_pkg::PRIO_WORDS*pvic_pkg::DATA_W-1:0]   levels_o
);

	// Each word is its own register so the arbiter sees all fields in parallel.
	genvar w;
	generate
		for (w = 0; w < pvic_pkg::PRIO_WORDS; w++) begin : g_word
			logic [pvic_pkg::DATA_W-1:0] word_ff;
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					word_ff <= pvic_pkg::RST_WORD;
				end else if (wr_en_i && (wr_idx_i == 4'(w))) begin
					word_ff <= wr_data_i;
				end
			end
			assign levels_o[w*pvic_pkg::DATA_W +: pvic_pkg::DATA_W] = word_ff;
		end
	endgenerate

endmodule : pvic_prio_mem

// ---- pvic_arbiter.sv ----
// Prioritized vector interrupt arbiter: register file, level arbitration,
// vector address generation, fast vectors and low-power wake request.
// Assumes core mask and service level arrive synchronous to ref_clk_i.
//
// Function
// [RULE1] 86 sources, programmable two-bit level each; here sources 0 and 1 are fixed at level 3
// [RULE2] Within level, lowest source number wins
// [RULE3] Signal core and supply jump address
// [RULE4] Normal vector is base concatenated with number
// [RULE5] Core mask bits block lower priorities
// [RULE6] Current service level limits nesting
// [RULE7] Software sets level 2, match, address
// [RULE8] Level-2 match against fast registers means fast
// [RULE9] Fast interrupt uses fast address pair
// [RULE10] Core fetches vector; non-jump starts fast path
// [RULE11] Reset drives initial program address
// [RULE12] Pending request wakes clocks in low power
// [RULE13] Only requests enabled before sleep wake
// [RULE14] Pins level sensitive during wait/stop
// [RULE15] In stop only CAN, pins wake
// [RULE16] Register slave, base plus offset addressing
// [RULE17] Highest unmasked level first, index breaks ties
`timescale 1ns/1ps
module pvic_arbiter #(
	parameter logic [pvic_pkg::VADDR_W-1:0] RESET_VADDR = 21'h00_0000
) (
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_i,
	input  wire pvic_pkg::pvic_bus_req_t       bus_req_i,
	output logic [pvic_pkg::DATA_W-1:0]        bus_rdata_o,
	input  wire logic [pvic_pkg::NUM_SRC-1:0]  irq_src_i,
	input  wire logic                          external_irq_pin_a_n_i,
	input  wire logic                          external_irq_pin_b_n_i,
	input  wire logic [1:0]                    core_status_word_mask_i,
	input  wire logic [1:0]                    current_service_level_i,
	input  wire logic                          irq_ack_i,
	input  wire logic                          low_power_i,
	input  wire logic                          stop_mode_i,
	output logic                               irq_req_o,
	output logic [pvic_pkg::LVL_W-1:0]         irq_level_o,
	output logic [pvic_pkg::SRC_W-1:0]         vector_num_o,
	output logic [pvic_pkg::VADDR_W-1:0]       vector_addr_o,
	output logic                               fast_o,
	output logic                               wake_o
);

	localparam int N = pvic_pkg::NUM_SRC;

	logic [pvic_pkg::PRIO_WORDS*pvic_pkg::DATA_W-1:0] levels;
	logic [pvic_pkg::VBA_W-1:0]  vba_ff;
	logic [pvic_pkg::SRC_W-1:0]  fm0_ff;
	logic [pvic_pkg::SRC_W-1:0]  fm1_ff;
	logic [pvic_pkg::DATA_W-1:0] fal0_ff;
	logic [pvic_pkg::DATA_W-1:0] fal1_ff;
	logic [pvic_pkg::FAH_W-1:0]  fah0_ff;
	logic [pvic_pkg::FAH_W-1:0]  fah1_ff;
	logic [1:0]                  edge_mode_ff;
	logic [1:0]                  pin_prev_ff;
	logic [1:0]                  pin_flag_ff;
	logic                        lp_prev_ff;
	logic [N-1:0]                snap_en_ff;
	logic [N-1:0]                req;
	logic [N-1:0]                elig;
	logic [N-1:0]                clockless;
	logic [N-1:0]                wake_cand;
	logic [N*pvic_pkg::LVL_W-1:0] src_lvl;
	logic [pvic_pkg::LVL_W-1:0]  min_lvl;
	logic                        found;
	logic [pvic_pkg::LVL_W-1:0]  best_lvl;
	logic [pvic_pkg::SRC_W-1:0]  best_idx;
	logic                        hit0;
	logic                        hit1;
	logic [1:0]                  pin_level;
	logic [1:0]                  pin_req;
	logic                        wr_prio;
	logic [3:0]                  prio_idx;
	logic [pvic_pkg::DATA_W-1:0] nxt_rdata;
	logic                        stop_src_any;

	// Priority words live in their own store; offsets 0..9 and the eleventh word.
	assign wr_prio  = bus_req_i.wr && ((bus_req_i.addr <= pvic_pkg::OFS_PRIO_LAST) ||
	                  (bus_req_i.addr == pvic_pkg::OFS_PRIO10)); // RULE16
	assign prio_idx = (bus_req_i.addr == pvic_pkg::OFS_PRIO10) ? pvic_pkg::PRIO10_IDX :
	                  bus_req_i.addr[3:0];

	pvic_prio_mem i_pvic_prio_mem (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_prio),
		.wr_idx_i  (prio_idx),
		.wr_data_i (bus_req_i.wdata),
		.levels_o  (levels)
	);

	// Vector base, fast match and fast address registers; reserved bits drop.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			vba_ff       <= pvic_pkg::RST_WORD[pvic_pkg::VBA_W-1:0];
			fm0_ff       <= pvic_pkg::RST_WORD[pvic_pkg::SRC_W-1:0];
			fm1_ff       <= pvic_pkg::RST_WORD[pvic_pkg::SRC_W-1:0];
			fal0_ff      <= pvic_pkg::RST_WORD;
			fal1_ff      <= pvic_pkg::RST_WORD;
			fah0_ff      <= pvic_pkg::RST_WORD[pvic_pkg::FAH_W-1:0];
			fah1_ff      <= pvic_pkg::RST_WORD[pvic_pkg::FAH_W-1:0];
			edge_mode_ff <= pvic_pkg::RST_EDGE;
		end else if (bus_req_i.wr) begin
			case (bus_req_i.addr)
				pvic_pkg::OFS_VBA:  vba_ff  <= bus_req_i.wdata[pvic_pkg::VBA_W-1:0]; // RULE16
				pvic_pkg::OFS_FM0:  fm0_ff  <= bus_req_i.wdata[pvic_pkg::SRC_W-1:0]; // RULE16
				pvic_pkg::OFS_FAL0: fal0_ff <= bus_req_i.wdata;
				pvic_pkg::OFS_FAH0: fah0_ff <= bus_req_i.wdata[pvic_pkg::FAH_W-1:0];
				pvic_pkg::OFS_FM1:  fm1_ff  <= bus_req_i.wdata[pvic_pkg::SRC_W-1:0];
				pvic_pkg::OFS_FAL1: fal1_ff <= bus_req_i.wdata;
				pvic_pkg::OFS_FAH1: fah1_ff <= bus_req_i.wdata[pvic_pkg::FAH_W-1:0];
				pvic_pkg::OFS_CTRL: edge_mode_ff <= bus_req_i.wdata[pvic_pkg::CTRL_EDGE_B:
				                                    pvic_pkg::CTRL_EDGE_A];
				default: ;
			endcase
		end
	end

	// Pins are active low. In low power there is no clock to catch an edge,
	// so the level itself requests regardless of the edge mode setting.
	assign pin_level = {~external_irq_pin_b_n_i, ~external_irq_pin_a_n_i};

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_prev_ff <= 2'h0;
		end else begin
			pin_prev_ff <= pin_level;
		end
	end

	// Edge flags: an edge arriving with the acknowledge still sets the flag.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_flag_ff <= 2'h0;
		end else begin
			pin_flag_ff[0] <= (pin_level[0] & ~pin_prev_ff[0]) | (pin_flag_ff[0] &
			                  ~(irq_ack_i && vector_num_o == 7'(pvic_pkg::PIN_A_SRC)));
			pin_flag_ff[1] <= (pin_level[1] & ~pin_prev_ff[1]) | (pin_flag_ff[1] &
			                  ~(irq_ack_i && vector_num_o == 7'(pvic_pkg::PIN_B_SRC)));
		end
	end

	assign pin_req[0] = (low_power_i || !edge_mode_ff[0]) ? pin_level[0] : pin_flag_ff[0]; // RULE14
	assign pin_req[1] = (low_power_i || !edge_mode_ff[1]) ? pin_level[1] : pin_flag_ff[1]; // RULE14

	// Lowest level that may still interrupt: the stricter of mask and service level.
	always_comb begin
		logic [pvic_pkg::LVL_W-1:0] cur_min;
		cur_min = current_service_level_i; // RULE6
		min_lvl = (core_status_word_mask_i > cur_min) ? core_status_word_mask_i : cur_min; // RULE5
	end

	// Per-source level, request and eligibility.
	genvar n;
	generate
		for (n = 0; n < N; n++) begin : g_src
			if (n < pvic_pkg::NUM_FIXED) begin : g_fixed
				assign src_lvl[2*n +: 2] = pvic_pkg::FIXED_LVL; // RULE1
			end else begin : g_prog
				assign src_lvl[2*n +: 2] = levels[2*n +: 2]; // RULE1
			end
			if (n == pvic_pkg::PIN_A_SRC) begin : g_pa
				assign req[n] = pin_req[0];
			end else if (n == pvic_pkg::PIN_B_SRC) begin : g_pb
				assign req[n] = pin_req[1];
			end else begin : g_plain
				assign req[n] = irq_src_i[n];
			end
			assign clockless[n] = (n == pvic_pkg::PIN_A_SRC) || (n == pvic_pkg::PIN_B_SRC) ||
			                      (n == pvic_pkg::CAN_WAKE_SRC);
			assign elig[n] = req[n] && (src_lvl[2*n +: 2] >= min_lvl);
		end
	endgenerate

	// Scan from the top down: a higher level always replaces, an equal level
	// replaces too, so the lowest index at the top level survives.
	always_comb begin
		found    = 1'b0;
		best_lvl = 2'h0;
		best_idx = 7'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (elig[i] && (!found || src_lvl[2*i +: 2] >= best_lvl)) begin // RULE17
				found    = 1'b1;
				best_lvl = src_lvl[2*i +: 2];
				best_idx = 7'(i); // RULE2
			end
		end
	end

	assign hit0 = (best_lvl == pvic_pkg::FAST_LVL) && (best_idx == fm0_ff); // RULE8
	assign hit1 = (best_lvl == pvic_pkg::FAST_LVL) && (best_idx == fm1_ff); // RULE8

	// Presentation to the core; the address holds between requests, so after
	// reset the initial program address stands on the bus.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_req_o     <= 1'b0;
			irq_level_o   <= 2'h0;
			vector_num_o  <= 7'h00;
			vector_addr_o <= RESET_VADDR; // RULE11
			fast_o        <= 1'b0;
		end else begin
			irq_req_o <= found && !low_power_i; // RULE3
			if (found) begin
				irq_level_o  <= best_lvl;
				vector_num_o <= best_idx;
				fast_o       <= hit0 || hit1;
				if (hit0) begin
					vector_addr_o <= {fah0_ff, fal0_ff}; // RULE9
				end else if (hit1) begin
					vector_addr_o <= {fah1_ff, fal1_ff}; // RULE9
				end else begin
					vector_addr_o <= {1'b0, vba_ff, best_idx}; // RULE4
				end
			end
		end
	end

	// Snapshot of what was enabled at the moment low power was entered.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			lp_prev_ff <= 1'b0;
			snap_en_ff <= '0;
		end else begin
			lp_prev_ff <= low_power_i;
			if (low_power_i && !lp_prev_ff) begin
				for (int i = 0; i < N; i++) begin
					snap_en_ff[i] <= (src_lvl[2*i +: 2] >= min_lvl); // RULE13
				end
			end
		end
	end

	// Stop leaves only clockless sources able to request.
	assign wake_cand = req & snap_en_ff & (stop_mode_i ? clockless : {N{1'b1}}); // RULE15

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wake_o <= 1'b0;
		end else begin
			wake_o <= low_power_i && lp_prev_ff && (|wake_cand); // RULE12
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		nxt_rdata = 16'h0000;
		if (bus_req_i.addr <= pvic_pkg::OFS_PRIO_LAST) begin
			nxt_rdata = levels[16*bus_req_i.addr[3:0] +: 16];
		end else if (bus_req_i.addr >= pvic_pkg::OFS_PEND_FIRST &&
		             bus_req_i.addr <= pvic_pkg::OFS_PEND_LAST) begin
			for (int b = 0; b < pvic_pkg::DATA_W; b++) begin
				if (16 * int'(bus_req_i.addr - pvic_pkg::OFS_PEND_FIRST) + b < N) begin
					nxt_rdata[b] = req[16 * int'(bus_req_i.addr - pvic_pkg::OFS_PEND_FIRST) + b];
				end
			end
		end else begin
			case (bus_req_i.addr)
				pvic_pkg::OFS_VBA:    nxt_rdata = 16'(vba_ff);
				pvic_pkg::OFS_FM0:    nxt_rdata = 16'(fm0_ff);
				pvic_pkg::OFS_FAL0:   nxt_rdata = fal0_ff;
				pvic_pkg::OFS_FAH0:   nxt_rdata = 16'(fah0_ff);
				pvic_pkg::OFS_FM1:    nxt_rdata = 16'(fm1_ff);
				pvic_pkg::OFS_FAL1:   nxt_rdata = fal1_ff;
				pvic_pkg::OFS_FAH1:   nxt_rdata = 16'(fah1_ff);
				pvic_pkg::OFS_PRIO10: nxt_rdata = levels[16*pvic_pkg::PRIO10_IDX +: 16];
				pvic_pkg::OFS_CTRL:   nxt_rdata = {11'h000, wake_o, current_service_level_i,
				                                   edge_mode_ff};
				default:              nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bus_rdata_o <= 16'h0000;
		end else if (bus_req_i.rd) begin
			bus_rdata_o <= nxt_rdata; // RULE16
		end
	end

	// A clockless source that was enabled at entry is requesting; the stop check reads it.
	assign stop_src_any = |(req & clockless & snap_en_ff);

	// Checks on the arbiter's outputs against their causes.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_fixed_src_level: assert property (irq_req_o && vector_num_o < 7'(pvic_pkg::NUM_FIXED)
		|-> irq_level_o == pvic_pkg::FIXED_LVL) else $error("fixed source level wrong"); // RULE1
	a_src0_wins_top: assert property (elig[0] && src_lvl[1:0] == 2'h3 && !low_power_i
		|=> irq_req_o && vector_num_o == 7'h00) else $error("source 0 not chosen"); // RULE2
	a_req_presented: assert property (found && !low_power_i |=> irq_req_o)
		else $error("eligible request not presented"); // RULE3
	a_normal_vector: assert property (irq_req_o && !fast_o
		|-> vector_addr_o == {1'b0, $past(vba_ff), vector_num_o}) else $error("bad vector"); // RULE4
	a_mask_honoured: assert property (irq_req_o
		|-> irq_level_o >= $past(core_status_word_mask_i)) else $error("masked level"); // RULE5
	a_nest_honoured: assert property (irq_req_o
		|-> irq_level_o >= $past(current_service_level_i)) else $error("nesting broken"); // RULE6
	a_fast_is_lvl2: assert property (irq_req_o && fast_o |-> irq_level_o == pvic_pkg::FAST_LVL)
		else $error("fast not level 2"); // RULE8
	a_fast_addr_pair: assert property (found && hit0
		|=> vector_addr_o == {$past(fah0_ff), $past(fal0_ff)}) else $error("fast address wrong"); // RULE9
	a_reset_vector: assert property ($past(rst_i) && !found |-> vector_addr_o == RESET_VADDR)
		else $error("reset address missing"); // RULE11
	a_wake_raised: assert property (low_power_i && lp_prev_ff && (|wake_cand) |=> wake_o)
		else $error("wake not raised"); // RULE12
	a_stop_wake_src: assert property (wake_o && $past(stop_mode_i)
		|-> $past(stop_src_any)) else $error("bad stop wake"); // RULE15

	c_normal_irq: cover property (irq_req_o && !fast_o);
	c_fast_irq:   cover property (irq_req_o && fast_o);
	c_stop_wake:  cover property (stop_mode_i ##1 wake_o);
	c_pin_edge:   cover property (edge_mode_ff[0] && pin_flag_ff[0] ##1 irq_req_o);

endmodule : pvic_arbiter

// ---- pvic_core_model.sv ----
// Behavioural model of the processor core that stands behind the arbiter.
// Assumes the arbiter presents a level request and takes a one-cycle ack.
`timescale 1ns/1ps
module pvic_core_model (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        irq_req_i,
	input  wire logic [20:0] vector_addr_i,
	input  wire logic        fast_i,
	input  wire logic        take_en_i,
	input  wire logic        slow_i,
	output logic             irq_ack_o,
	output logic [20:0]      fetch_addr_o,
	output logic             fast_path_o,
	output int               fetch_cnt_o
);
	int   wait_ff;
	logic busy_ff;

	// Take a presented vector once, promptly or after four idle cycles.
	// A held request is taken only once, so level sources are not re-acked.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_ack_o    <= 1'b0;
			busy_ff      <= 1'b0;
			wait_ff      <= 0;
			fetch_addr_o <= 21'h00_0000;
			fast_path_o  <= 1'b0;
			fetch_cnt_o  <= 0;
		end else begin
			irq_ack_o <= 1'b0;
			if (!irq_req_i) begin
				busy_ff <= 1'b0;
				wait_ff <= 0;
			end else if (take_en_i && !busy_ff) begin
				wait_ff <= wait_ff + 1;
				if (wait_ff >= (slow_i ? 4 : 0)) begin
					irq_ack_o    <= 1'b1;
					busy_ff      <= 1'b1;
					fetch_addr_o <= vector_addr_i;
					fast_path_o  <= fast_i;
					fetch_cnt_o  <= fetch_cnt_o + 1;
				end
			end
		end
	end
endmodule : pvic_core_model

// ---- prioritized_vector_interrupt_ctrl_bench.sv ----
// Self-checking bench for the interrupt arbiter with a core model.
// Assumes the arbiter answers one or two edges after its inputs settle.
`timescale 1ns/1ps
module prioritized_vector_interrupt_ctrl_bench;
	localparam int MAX_CYC = 3000;
	logic                    ref_clk_i  = 1'b0;
	logic                    rst_i      = 1'b1;
	pvic_pkg::pvic_bus_req_t bus_req    = '0;
	logic [85:0]             src        = '0;
	logic                    pin_a_n    = 1'b1;
	logic                    pin_b_n    = 1'b1;
	logic [1:0]              mask       = 2'h0;
	logic [1:0]              svc        = 2'h0;
	logic                    lp         = 1'b0;
	logic                    stp        = 1'b0;
	logic                    take_en    = 1'b0;
	logic                    slow       = 1'b0;
	logic [15:0]             rdata;
	logic                    ack;
	logic                    req;
	logic                    fast;
	logic                    wake;
	logic                    fpath;
	logic [1:0]              lvl;
	logic [6:0]              num;
	logic [20:0]             vaddr;
	logic [20:0]             faddr;
	int                      fcnt;
	int                      fail_count = 0;
	int                      checks     = 0;
	int                      cyc        = 0;
	logic [15:0]             prio_sh [0:10] = '{default: 16'h0000};

	pvic_arbiter i_pvic_arbiter (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req),
		.bus_rdata_o(rdata), .irq_src_i(src), .external_irq_pin_a_n_i(pin_a_n),
		.external_irq_pin_b_n_i(pin_b_n), .core_status_word_mask_i(mask),
		.current_service_level_i(svc), .irq_ack_i(ack), .low_power_i(lp),
		.stop_mode_i(stp), .irq_req_o(req), .irq_level_o(lvl),
		.vector_num_o(num), .vector_addr_o(vaddr), .fast_o(fast), .wake_o(wake));

	pvic_core_model i_pvic_core_model (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .irq_req_i(req),
		.vector_addr_i(vaddr), .fast_i(fast), .take_en_i(take_en),
		.slow_i(slow), .irq_ack_o(ack), .fetch_addr_o(faddr),
		.fast_path_o(fpath), .fetch_cnt_o(fcnt));

	// Free-running system clock.
	always #5 ref_clk_i = ~ref_clk_i;

	// Cycle ceiling, so a hung handshake still ends with a verdict.
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == MAX_CYC) begin
			fail_count++;
			$display("ERROR cycle_limit expected %0d seen %0d", MAX_CYC - 1, cyc);
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Each access leaves one idle cycle so no strobe is rewritten in a step.
	task automatic bus_write(input logic [5:0] a, input logic [15:0] d);
		bus_req = '{1'b1, 1'b0, a, d};
		tick(1);
		bus_req = '0;
		tick(1);
	endtask : bus_write

	task automatic bus_read(input logic [5:0] a, output logic [15:0] d);
		bus_req = '{1'b0, 1'b1, a, 16'h0000};
		tick(1);
		d = rdata;
		bus_req = '0;
		tick(1);
	endtask : bus_read

	// Read-modify-write through a shadow, since fields share words.
	task automatic set_level(input int s, input logic [1:0] l);
		int w;
		w = s / 8;
		prio_sh[w][2*(s%8)+:2] = l;
		bus_write((w < 10) ? w[5:0] : 6'h1F, prio_sh[w]);
	endtask : set_level

	task automatic t_regs();
		logic [15:0] d;
		logic [5:0]  a_t [4] = '{6'h0A, 6'h0B, 6'h0D, 6'h05};
		logic [15:0] e_t [4] = '{16'h1FFF, 16'h007F, 16'h001F, 16'hFFFF};
		chk("reset_vaddr", 0, vaddr);
		chk("reset_req", 0, req);
		for (int a = 0; a <= 16; a++) begin
			bus_read(a[5:0], d);
			chk("reset_word", 0, d);
		end
		for (int i = 0; i < 4; i++) begin
			bus_write(a_t[i], 16'hFFFF);
			bus_read(a_t[i], d);
			chk("rw_word", e_t[i], d);
			bus_write(a_t[i], 16'h0000);
		end
		bus_write(6'h18, 16'hFFFF);
		bus_read(6'h18, d);
		chk("unmapped", 0, d);
	endtask : t_regs

	task automatic t_tie();
		logic [15:0] d;
		bus_write(6'h0A, 16'h0123);
		set_level(5, 2'h1);
		set_level(40, 2'h1);
		src[5] = 1'b1;
		src[40] = 1'b1;
		tick(2);
		chk("tie_req", 1, req);
		chk("tie_num", 5, num);
		chk("tie_lvl", 1, lvl);
		chk("tie_vaddr", {1'b0, 13'h0123, 7'd5}, vaddr);
		// Source 40 shows up as bit 8 of the third pending word.
		bus_read(6'h13, d);
		chk("pending_word", 16'h0100, d);
		src[5] = 1'b0;
		tick(2);
		chk("tie_num2", 40, num);
		// Source 0 has the fixed top level, so it beats the programmed one.
		src[0] = 1'b1;
		tick(2);
		chk("fixed_num", 0, num);
		chk("fixed_lvl", 3, lvl);
		src[0] = 1'b0;
		src[40] = 1'b0;
	endtask : t_tie

	// The level of source 85 sits in the eleventh priority word at its own offset.
	task automatic t_levels();
		set_level(85, 2'h3);
		src[40] = 1'b1;
		src[85] = 1'b1;
		tick(2);
		chk("cross_num", 85, num);
		src[40] = 1'b0;
		for (int l = 0; l < 4; l++) begin
			set_level(85, l[1:0]);
			for (int m = 0; m < 4; m++) begin
				mask = m[1:0];
				tick(2);
				chk("mask_req", l >= m, req);
				mask = 2'h0;
				svc = m[1:0];
				tick(2);
				chk("nest_req", l >= m, req);
				svc = 2'h0;
			end
		end
		src[85] = 1'b0;
	endtask : t_levels

	task automatic t_fast();
		set_level(20, 2'h2);
		bus_write(6'h0E, 16'h0014);
		bus_write(6'h0F, 16'hBEEF);
		bus_write(6'h10, 16'h0015);
		take_en = 1'b1;
		slow = 1'b1;
		src[20] = 1'b1;
		tick(8);
		chk("fast_flag", 1, fast);
		chk("fast_vaddr", 21'h15_BEEF, vaddr);
		chk("fetch_addr", 21'h15_BEEF, faddr);
		chk("fast_path", 1, fpath);
		bus_write(6'h0B, 16'h0014);
		bus_write(6'h0C, 16'h1234);
		bus_write(6'h0D, 16'h0003);
		tick(2);
		chk("fast0_vaddr", 21'h03_1234, vaddr);
		set_level(20, 2'h1);
		tick(2);
		chk("lvl1_fast", 0, fast);
		chk("lvl1_vaddr", {1'b0, 13'h0123, 7'd20}, vaddr);
		src[20] = 1'b0;
		take_en = 1'b0;
		slow = 1'b0;
		tick(2);
	endtask : t_fast

	// An edge-mode pin, once acked, must still wake while held low asleep.
	task automatic t_edge_sleep();
		int          n0;
		logic [15:0] d;
		bus_write(6'h1D, 16'h0001);
		set_level(2, 2'h1);
		take_en = 1'b1;
		n0 = fcnt;
		pin_a_n = 1'b0;
		tick(10);
		chk("edge_taken", n0 + 1, fcnt);
		chk("edge_addr", {1'b0, 13'h0123, 7'd2}, faddr);
		chk("edge_clear", 0, req);
		take_en = 1'b0;
		lp = 1'b1;
		stp = 1'b1;
		tick(4);
		chk("pin_wake", 1, wake);
		pin_a_n = 1'b1;
		set_level(30, 2'h1);
		set_level(4, 2'h1);
		src[30] = 1'b1;
		tick(3);
		chk("stop_clk_src", 0, wake);
		src[4] = 1'b1;
		tick(3);
		chk("stop_can", 1, wake);
		chk("sleep_req", 0, req);
		src[4] = 1'b0;
		src[30] = 1'b0;
		lp = 1'b0;
		stp = 1'b0;
		tick(2);
		lp = 1'b1;
		tick(2);
		src[30] = 1'b1;
		tick(3);
		chk("wait_wake", 1, wake);
		src[30] = 1'b0;
		lp = 1'b0;
		mask = 2'h2;
		tick(2);
		lp = 1'b1;
		tick(2);
		mask = 2'h0;
		src[30] = 1'b1;
		tick(3);
		chk("late_enable", 0, wake);
		src[30] = 1'b0;
		lp = 1'b0;
		// Pin B in edge mode: the falling edge alone raises source 3.
		bus_write(6'h1D, 16'h0002);
		pin_b_n = 1'b0;
		tick(3);
		chk("pin_b_req", 1, req);
		chk("pin_b_num", 3, num);
		bus_read(6'h1D, d);
		chk("ctrl_word", 16'h0002, d);
		pin_b_n = 1'b1;
	endtask : t_edge_sleep

	initial begin
		repeat (5) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		tick(1);
		t_regs();
		t_tie();
		t_levels();
		t_fast();
		t_edge_sleep();
		summarize();
	end
endmodule : prioritized_vector_interrupt_ctrl_bench
